/* rtl/cmcr_regs.v */
//----------------------------------------------------------------
// Function
// - Node address accepts 0 to 255; new value used only after restart.
// - Baud code 4 to 10 picks 2400 up to 115200; active after restart.
// - Parity 0 none, 1 odd, 2 even; framing adopts it after restart.
// - Encoder frequency is a float over two words, low word first.
// - Each channel frequency is a float pair, low half first.
// - Each channel speed is an unsigned read-only word.
// - Encoder speed is signed; the sign gives direction of rotation.
// - Each channel has its own read/write filter time in milliseconds.
// - A filter time change takes effect only after restart.
// - Mode 0 is one encoder, mode 1 two counters; mode picks results.
//----------------------------------------------------------------
`timescale 1ns/1ps
`include "cmcr_defines.vh"

module cmcr_regs #(
    parameter [7:0] ID_HI = 8'h5a, // Arbitrary identity value.
    parameter [7:0] ID_LO = 8'h3c  // Arbitrary identity value.
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire op_mode,
    input wire meas_strobe,
    input wire [15:0] enc_speed,
    input wire [31:0] enc_freq,
    input wire [15:0] cha_speed,
    input wire [15:0] chb_speed,
    input wire [31:0] cha_freq,
    input wire [31:0] chb_freq,
    input wire [15:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    output reg reg_ack,
    output reg reg_err,
    input wire restart,
    output wire [7:0] act_node_addr,
    output wire [3:0] act_baud_code,
    output reg [16:0] act_bit_rate,
    output wire [1:0] act_parity,
    output wire [15:0] act_filt_a,
    output wire [15:0] act_filt_b
);

    // ----------------------------------------------------------------
    // Configuration entries
    // ----------------------------------------------------------------
    localparam [16*`CMCR_NUM_CFG-1:0] CFG_ADDR = {`CMCR_ADDR_FILT_B,
        `CMCR_ADDR_FILT_A, `CMCR_ADDR_PARITY, `CMCR_ADDR_BAUD, `CMCR_ADDR_NODE};
    localparam [16*`CMCR_NUM_CFG-1:0] CFG_DEF = {`CMCR_FILT_DEF,
        `CMCR_FILT_DEF, `CMCR_PAR_DEF, `CMCR_BAUD_DEF, `CMCR_NODE_DEF};
    localparam [16*`CMCR_NUM_CFG-1:0] CFG_MIN = {`CMCR_FILT_MIN,
        `CMCR_FILT_MIN, `CMCR_PAR_MIN, `CMCR_BAUD_MIN, `CMCR_NODE_MIN};
    localparam [16*`CMCR_NUM_CFG-1:0] CFG_MAX = {`CMCR_FILT_MAX,
        `CMCR_FILT_MAX, `CMCR_PAR_MAX, `CMCR_BAUD_MAX, `CMCR_NODE_MAX};

    wire [`CMCR_NUM_CFG-1:0] cfg_hit;
    wire [`CMCR_NUM_CFG-1:0] cfg_bad;
    wire [16*`CMCR_NUM_CFG-1:0] cfg_stored;
    wire [16*`CMCR_NUM_CFG-1:0] cfg_active;

    // Each entry keeps a stored and an active copy of its word.
    genvar gi;
    generate
        for (gi = 0; gi < `CMCR_NUM_CFG; gi = gi + 1) begin : g_cfg
            cmcr_cfg_entry #(
                .ADDR(CFG_ADDR[16*gi +: 16]),
                .DEF(CFG_DEF[16*gi +: 16]),
                .MIN(CFG_MIN[16*gi +: 16]),
                .MAX(CFG_MAX[16*gi +: 16])
            ) u_entry (
                .clk(clk),
                .rst(rst),
                .ce(ce),
                .wr(reg_wr),
                .addr(reg_addr),
                .wdata(reg_wdata),
                .restart(restart),
                .hit(cfg_hit[gi]),
                .bad(cfg_bad[gi]),
                .stored(cfg_stored[16*gi +: 16]),
                .active(cfg_active[16*gi +: 16])
            );
        end
    endgenerate

    // Active copies drive the serial side and the input filters.
    assign act_node_addr = cfg_active[`CMCR_NODE_W-1:0];
    assign act_baud_code = cfg_active[16 +: `CMCR_BAUD_W];
    assign act_parity = cfg_active[32 +: `CMCR_PAR_W];
    assign act_filt_a = cfg_active[48 +: 16];
    assign act_filt_b = cfg_active[64 +: 16];

    // Bit rate looked up from the active code, in code order.
    always @(posedge clk) begin
        if (rst) begin
            act_bit_rate <= `CMCR_RATE_9600;
        end else if (ce) begin
            case (act_baud_code)
                4'h4: act_bit_rate <= `CMCR_RATE_2400;
                4'h5: act_bit_rate <= `CMCR_RATE_4800;
                4'h6: act_bit_rate <= `CMCR_RATE_9600;
                4'h7: act_bit_rate <= `CMCR_RATE_19200;
                4'h8: act_bit_rate <= `CMCR_RATE_38400;
                4'h9: act_bit_rate <= `CMCR_RATE_57600;
                4'ha: act_bit_rate <= `CMCR_RATE_115200;
                default: act_bit_rate <= `CMCR_RATE_9600;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Measurement results
    // ----------------------------------------------------------------
    reg [15:0] enc_speed_r;
    reg [31:0] enc_freq_r;
    reg [15:0] cha_speed_r;
    reg [15:0] chb_speed_r;
    reg [31:0] cha_freq_r;
    reg [31:0] chb_freq_r;

    // Only the results of the running mode are captured; the others are
    // zeroed at each strobe, so a stale value from the other mode shows only until the next strobe.
    always @(posedge clk) begin
        if (rst) begin
            enc_speed_r <= 16'h0000;
            enc_freq_r <= 32'h0000_0000;
            cha_speed_r <= 16'h0000;
            chb_speed_r <= 16'h0000;
            cha_freq_r <= 32'h0000_0000;
            chb_freq_r <= 32'h0000_0000;
        end else if (ce && meas_strobe) begin
            if (op_mode == `CMCR_MODE_ENCODER) begin
                enc_speed_r <= enc_speed;
                enc_freq_r <= enc_freq;
                cha_speed_r <= 16'h0000;
                chb_speed_r <= 16'h0000;
                cha_freq_r <= 32'h0000_0000;
                chb_freq_r <= 32'h0000_0000;
            end else begin
                enc_speed_r <= 16'h0000;
                enc_freq_r <= 32'h0000_0000;
                cha_speed_r <= cha_speed;
                chb_speed_r <= chb_speed;
                cha_freq_r <= cha_freq;
                chb_freq_r <= chb_freq;
            end
        end
    end

    // ----------------------------------------------------------------
    // High-word shadow for coherent float reads
    // ----------------------------------------------------------------
    reg [15:0] hi_shadow_r;
    reg [15:0] hi_tag_r;
    reg hi_valid_r;
    reg [15:0] hi_live;
    reg lo_hit;

    // A low-word read snapshots its high word; the matching high-word read
    // then returns the snapshot even if a new sample arrived in between.
    always @* begin
        lo_hit = 1'b1;
        hi_live = 16'h0000;
        case (reg_addr)
            `CMCR_ADDR_ENC_FREQ: hi_live = enc_freq_r[31:16];
            `CMCR_ADDR_CHA_FREQ: hi_live = cha_freq_r[31:16];
            `CMCR_ADDR_CHB_FREQ: hi_live = chb_freq_r[31:16];
            default: lo_hit = 1'b0;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            hi_shadow_r <= 16'h0000;
            hi_tag_r <= 16'h0000;
            hi_valid_r <= 1'b0;
        end else if (ce && reg_rd) begin
            hi_valid_r <= lo_hit;
            hi_shadow_r <= hi_live;
            hi_tag_r <= reg_addr + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Read multiplexer
    // ----------------------------------------------------------------
    reg [15:0] rd_word;
    reg rd_map;
    wire hi_use = hi_valid_r && (reg_addr == hi_tag_r);

    always @* begin
        rd_map = 1'b1;
        rd_word = 16'h0000;
        case (reg_addr)
            `CMCR_ADDR_ENC_SPEED: rd_word = enc_speed_r;
            `CMCR_ADDR_CHA_SPEED: rd_word = cha_speed_r;
            `CMCR_ADDR_CHB_SPEED: rd_word = chb_speed_r;
            `CMCR_ADDR_ENC_FREQ: rd_word = enc_freq_r[15:0];
            `CMCR_ADDR_ENC_FREQ + 16'h0001:
                rd_word = hi_use ? hi_shadow_r : enc_freq_r[31:16];
            `CMCR_ADDR_CHA_FREQ: rd_word = cha_freq_r[15:0];
            `CMCR_ADDR_CHA_FREQ + 16'h0001:
                rd_word = hi_use ? hi_shadow_r : cha_freq_r[31:16];
            `CMCR_ADDR_CHB_FREQ: rd_word = chb_freq_r[15:0];
            `CMCR_ADDR_CHB_FREQ + 16'h0001:
                rd_word = hi_use ? hi_shadow_r : chb_freq_r[31:16];
            `CMCR_ADDR_IDENT: rd_word = {ID_HI, ID_LO};
            `CMCR_ADDR_NODE: rd_word = cfg_stored[15:0];
            `CMCR_ADDR_BAUD: rd_word = cfg_stored[31:16];
            `CMCR_ADDR_PARITY: rd_word = cfg_stored[47:32];
            `CMCR_ADDR_FILT_A: rd_word = cfg_stored[63:48];
            `CMCR_ADDR_FILT_B: rd_word = cfg_stored[79:64];
            default: rd_map = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Answer to the framing logic
    // ----------------------------------------------------------------
    // Writes to read-only or unmapped words, and out-of-range codes, are
    // refused with an error pulse; the stored words stay unchanged.
    always @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
            reg_ack <= 1'b0;
            reg_err <= 1'b0;
        end else if (ce) begin
            reg_ack <= 1'b0;
            reg_err <= 1'b0;
            if (reg_rd) begin
                reg_rdata <= rd_map ? rd_word : 16'h0000;
                reg_ack <= rd_map;
                reg_err <= !rd_map;
            end else if (reg_wr) begin
                reg_ack <= (|cfg_hit) && !(|cfg_bad);
                reg_err <= !(|cfg_hit) || (|cfg_bad);
            end
        end
    end

endmodule

/* rtl/cmcr_defines.vh */
`ifndef CMCR_DEFINES_VH
`define CMCR_DEFINES_VH

// ----------------------------------------------------------------
// Holding register offsets
// ----------------------------------------------------------------
`define CMCR_ADDR_ENC_SPEED 16'h0064
`define CMCR_ADDR_CHA_SPEED 16'h006c
`define CMCR_ADDR_CHB_SPEED 16'h006d
`define CMCR_ADDR_ENC_FREQ 16'h0080
`define CMCR_ADDR_CHA_FREQ 16'h0090
`define CMCR_ADDR_CHB_FREQ 16'h0092
`define CMCR_ADDR_FILT_A 16'h00b4
`define CMCR_ADDR_FILT_B 16'h00b5
`define CMCR_ADDR_NODE 16'h00c8
`define CMCR_ADDR_BAUD 16'h00c9
`define CMCR_ADDR_PARITY 16'h00ca
`define CMCR_ADDR_IDENT 16'h00d2

// ----------------------------------------------------------------
// Legal ranges and reset values of the configuration words
// ----------------------------------------------------------------
`define CMCR_NODE_MIN 16'h0000
`define CMCR_NODE_MAX 16'h00ff
`define CMCR_NODE_DEF 16'h0003
`define CMCR_BAUD_MIN 16'h0004
`define CMCR_BAUD_MAX 16'h000a
`define CMCR_BAUD_DEF 16'h0006
`define CMCR_PAR_MIN 16'h0000
`define CMCR_PAR_MAX 16'h0002
`define CMCR_PAR_DEF 16'h0000
`define CMCR_FILT_MIN 16'h0000
`define CMCR_FILT_MAX 16'hffff
`define CMCR_FILT_DEF 16'h0000

// ----------------------------------------------------------------
// Codes, modes and field widths
// ----------------------------------------------------------------
`define CMCR_PAR_NONE 2'h0
`define CMCR_PAR_ODD 2'h1
`define CMCR_PAR_EVEN 2'h2
`define CMCR_MODE_ENCODER 1'b0
`define CMCR_MODE_COUNTERS 1'b1
`define CMCR_NODE_W 8
`define CMCR_BAUD_W 4
`define CMCR_PAR_W 2
`define CMCR_RATE_W 17
`define CMCR_NUM_CFG 5

// ----------------------------------------------------------------
// Bit rates of the baud codes, in bit/s
// ----------------------------------------------------------------
`define CMCR_RATE_2400 17'h00960
`define CMCR_RATE_4800 17'h012c0
`define CMCR_RATE_9600 17'h02580
`define CMCR_RATE_19200 17'h04b00
`define CMCR_RATE_38400 17'h09600
`define CMCR_RATE_57600 17'h0e100
`define CMCR_RATE_115200 17'h1c200

`endif

/* rtl/cmcr_cfg_entry.v */
`timescale 1ns/1ps
// One restart-effective configuration word: a stored copy that software
// writes and reads back, and an active copy that the logic uses.
module cmcr_cfg_entry #(
    parameter [15:0] ADDR = 16'h0000,
    parameter [15:0] DEF = 16'h0000,
    parameter [15:0] MIN = 16'h0000,
    parameter [15:0] MAX = 16'hffff
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire wr,
    input wire [15:0] addr,
    input wire [15:0] wdata,
    input wire restart,
    output wire hit,
    output wire bad,
    output wire [15:0] stored,
    output wire [15:0] active
);
    reg [15:0] stored_r;
    reg [15:0] active_r;

    // Out-of-range codes are refused so the stored copy never holds junk.
    assign hit = (addr == ADDR);
    assign bad = hit && ((wdata < MIN) || (wdata > MAX));
    assign stored = stored_r;
    assign active = active_r;

    // The active copy moves only on restart, never on the write itself.
    always @(posedge clk) begin
        if (rst) begin
            stored_r <= DEF;
            active_r <= DEF;
        end else if (ce) begin
            if (wr && hit && !bad) begin
                stored_r <= wdata;
            end
            if (restart) begin
                active_r <= stored_r;
            end
        end
    end
endmodule

/* verification/cmcr_asserts.sv */
`timescale 1ns/1ps
`include "cmcr_defines.vh"
// ----------------------------------------
// Register port checker
// ----------------------------------------
module cmcr_asserts (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire [15:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_wdata,
    input wire reg_ack,
    input wire reg_err,
    input wire restart,
    input wire [7:0] act_node_addr,
    input wire [3:0] act_baud_code,
    input wire [16:0] act_bit_rate,
    input wire [1:0] act_parity,
    input wire [15:0] act_filt_a,
    input wire [15:0] act_filt_b
);
    // Bit rates of codes 4 to 10, code 4 in the lowest slice.
    localparam [118:0] RATES = {17'h1c200, 17'h0e100, 17'h09600, 17'h04b00,
        17'h02580, 17'h012c0, 17'h00960};
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // A write that lands; a read wins when both strobes are up.
    sequence s_wr(a);
        ce && reg_wr && !reg_rd && reg_addr == a;
    endsequence
    // Filter write, one edge without writes, then a restart.
    sequence s_filt_restart;
        s_wr(`CMCR_ADDR_FILT_A) ##1 (ce && !reg_wr) ##1 (ce && restart && !reg_wr);
    endsequence
    a_one_answer: assert property (ce && (reg_rd || reg_wr) |=> reg_ack != reg_err)
        else $error("Request not answered by one flag.");
    a_node_range: assert property (s_wr(`CMCR_ADDR_NODE) |=>
        reg_err == ($past(reg_wdata) > 16'h00ff)) else $error("Node range wrong.");
    a_baud_range: assert property (s_wr(`CMCR_ADDR_BAUD) |=> reg_err ==
        ($past(reg_wdata) < 16'h0004 || $past(reg_wdata) > 16'h000a))
        else $error("Baud range wrong.");
    a_parity_range: assert property (s_wr(`CMCR_ADDR_PARITY) |=>
        reg_err == ($past(reg_wdata) > 16'h0002)) else $error("Parity range wrong.");
    a_cfg_hold: assert property (!(ce && restart) |=> $stable({act_node_addr,
        act_baud_code, act_parity, act_filt_a, act_filt_b})) else $error("Active moved.");
    a_rate_decode: assert property ($stable(act_baud_code) |->
        act_bit_rate == RATES[(act_baud_code - 4'h4) * 17 +: 17]) else $error("Bad rate.");
    a_ro_refused: assert property (s_wr(`CMCR_ADDR_CHA_SPEED) |=> reg_err)
        else $error("Read-only write accepted.");
    a_filt_restart: assert property (s_filt_restart |=>
        act_filt_a == $past(reg_wdata, 3)) else $error("Filter not applied.");
endmodule
bind cmcr_regs cmcr_asserts i_cmcr_asserts (.clk(clk), .rst(rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_ack(reg_ack), .reg_err(reg_err), .restart(restart),
    .act_node_addr(act_node_addr), .act_baud_code(act_baud_code),
    .act_bit_rate(act_bit_rate), .act_parity(act_parity), .act_filt_a(act_filt_a),
    .act_filt_b(act_filt_b));

/* verification/cmcr_host.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Host side of the register port
// ----------------------------------------
module cmcr_host (
    input wire clk,
    input wire [15:0] reg_rdata,
    input wire reg_ack,
    input wire reg_err,
    output reg [15:0] reg_addr,
    output reg reg_wr,
    output reg reg_rd,
    output reg [15:0] reg_wdata
);
    // Strobes low before the first edge.
    initial begin
        reg_addr = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end
    // One request; idle lines carry inverted values so stale data never matches.
    task acc(input w, input [15:0] a, input [15:0] d, output [15:0] q, output k,
        output e);
        @(posedge clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        #1;
        q = reg_rdata;
        k = reg_ack;
        e = reg_err;
    endtask
    // Both halves of a float in back-to-back reads, low word first.
    task rd_pair(input [15:0] a, output [31:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_addr <= a + 16'h0001;
        #1;
        v[15:0] = reg_rdata;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        v[31:16] = reg_rdata;
    endtask
endmodule

/* verification/testbench.sv */
`timescale 1ns/1ps
`include "cmcr_defines.vh"
// ----------------------------------------
// Register bank bench
// ----------------------------------------
module testbench;
    localparam [118:0] RATES = {17'h1c200, 17'h0e100, 17'h09600, 17'h04b00,
        17'h02580, 17'h012c0, 17'h00960};
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg restart = 1'b0;
    reg ce = 1'b1;
    reg op_mode = 1'b0;
    reg meas_strobe = 1'b0;
    reg [15:0] sp [0:2];
    reg [31:0] fq [0:2];
    wire [15:0] reg_addr, reg_wdata, reg_rdata;
    wire reg_wr, reg_rd, reg_ack, reg_err;
    wire [7:0] act_node_addr;
    wire [3:0] act_baud_code;
    wire [16:0] act_bit_rate;
    wire [1:0] act_parity;
    wire [15:0] act_filt_a, act_filt_b;
    integer num_errors = 0;
    integer check_count = 0;
    integer seed = 32'h3b930729;
    integer i, m;
    reg [15:0] q, nd, st_node, st_baud, st_par, st_fa, st_fb, st_id;
    reg [15:0] ex_node, ex_baud, ex_par, ex_fa, ex_fb;
    reg rk, re;
    reg [31:0] v;
    // Half period of a 25 MHz clock.
    always #20 clk = ~clk;
    cmcr_regs i_cmcr_regs (.clk(clk), .rst(rst), .ce(ce), .op_mode(op_mode),
        .meas_strobe(meas_strobe), .enc_speed(sp[0]), .enc_freq(fq[0]), .cha_speed(sp[1]),
        .chb_speed(sp[2]), .cha_freq(fq[1]), .chb_freq(fq[2]), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_ack(reg_ack), .reg_err(reg_err), .restart(restart),
        .act_node_addr(act_node_addr), .act_baud_code(act_baud_code),
        .act_bit_rate(act_bit_rate), .act_parity(act_parity), .act_filt_a(act_filt_a),
        .act_filt_b(act_filt_b));
    cmcr_host i_cmcr_host (.clk(clk), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .reg_err(reg_err), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata));
    task chk_val(input string n, input [31:0] x, input [31:0] g);
        check_count = check_count + 1;
        if (g !== x) begin
            num_errors = num_errors + 1;
            $display("MISMATCH %0s expected %h seen %h", n, x, g);
        end
    endtask
    task chk_rsp(input ok);
        check_count = check_count + 1;
        if ({rk, re} !== {ok, !ok}) begin
            num_errors = num_errors + 1;
            $display("MISMATCH ack_err expected %b seen %b", {ok, !ok}, {rk, re});
        end
    endtask
    task rd_chk(input [15:0] a, input [15:0] x);
        i_cmcr_host.acc(1'b0, a, 16'h0000, q, rk, re);
        chk_rsp(1'b1);
        chk_val($sformatf("reg %h", a), {16'h0000, x}, {16'h0000, q});
    endtask
    // Write, then read back what the bank should now hold.
    task cfg(input [15:0] a, input [15:0] d, input ok, inout [15:0] s);
        i_cmcr_host.acc(1'b1, a, d, q, rk, re);
        chk_rsp(ok);
        if (ok)
            s = d;
        rd_chk(a, s);
    endtask
    // Bit rate that a legal baud code must select.
    function [16:0] rate_of(input [15:0] code);
        rate_of = RATES[(code - 16'h0004) * 17 +: 17];
    endfunction
    task chk_act;
        chk_val("act cfg", {ex_node[7:0], ex_baud[3:0], ex_par[1:0],
            rate_of(ex_baud)},
            {act_node_addr, act_baud_code, act_parity, act_bit_rate});
        chk_val("act filt", {ex_fa, ex_fb}, {act_filt_a, act_filt_b});
    endtask
    // Rate lags the code by a cycle, so look one edge after the copy.
    task rs;
        @(posedge clk);
        restart <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
        @(posedge clk);
        #1;
        {ex_node, ex_baud, ex_par, ex_fa, ex_fb} = {st_node, st_baud, st_par, st_fa, st_fb};
    endtask
    task wrap_up;
        $display("Checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // The run needs under 400 cycles; a hang is cut at 10000 cycles, far beyond that.
    initial begin
        #400000;
        num_errors = num_errors + 1;
        $display("MISMATCH watchdog expected done seen hang");
        wrap_up;
    end
    initial begin
        for (i = 0; i < 3; i = i + 1) begin
            sp[i] = 16'h0000;
            fq[i] = 32'h00000000;
        end
        {st_node, st_baud, st_par, st_fa, st_fb} = {16'h3, 16'h6, 16'h0, 16'h0, 16'h0};
        {ex_node, ex_baud, ex_par, ex_fa, ex_fb} = {16'h3, 16'h6, 16'h0, 16'h0, 16'h0};
        st_id = 16'h5a3c;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        chk_act;
        // Every baud and parity code with refused neighbours; node edges then random.
        for (i = 0; i < 12; i = i + 1) begin
            nd = 16'($random(seed)) & 16'h01ff;
            if (i < 2)
                nd = 16'h00ff + i[15:0];
            cfg(`CMCR_ADDR_NODE, nd, nd <= 16'h00ff, st_node);
            cfg(`CMCR_ADDR_BAUD, i[15:0], i >= 4 && i <= 10, st_baud);
            cfg(`CMCR_ADDR_PARITY, i[15:0], i <= 2, st_par);
            cfg(`CMCR_ADDR_FILT_A, 16'($random(seed)), 1'b1, st_fa);
            cfg(`CMCR_ADDR_FILT_B, 16'($random(seed)), 1'b1, st_fb);
            chk_act;
            rs;
            chk_act;
        end
        i_cmcr_host.acc(1'b1, `CMCR_ADDR_FILT_A, 16'h0014, q, rk, re);
        st_fa = 16'h0014;
        rs;
        chk_act;
        i_cmcr_host.acc(1'b1, `CMCR_ADDR_CHA_SPEED, 16'h1234, q, rk, re);
        chk_rsp(1'b0);
        cfg(`CMCR_ADDR_IDENT, 16'h0001, 1'b0, st_id);
        i_cmcr_host.acc(1'b0, 16'h0000, 16'h0000, q, rk, re);
        chk_rsp(1'b0);
        chk_val("unmapped", 32'h0, {16'h0000, q});
        // With the enable low a legal write is neither taken, answered nor stored.
        @(posedge clk);
        ce <= 1'b0;
        i_cmcr_host.acc(1'b1, `CMCR_ADDR_NODE, {8'h00, ~st_node[7:0]}, q, rk, re);
        ce <= 1'b1;
        chk_val("frozen ack_err", 32'h0, {30'h0, rk, re});
        rd_chk(`CMCR_ADDR_NODE, st_node);
        // Each mode twice; results of the idle mode read zero.
        for (m = 0; m < 4; m = m + 1) begin
            @(posedge clk);
            op_mode <= m[0];
            meas_strobe <= 1'b1;
            for (i = 0; i < 3; i = i + 1) begin
                sp[i] <= 16'($random(seed));
                fq[i] <= $random(seed);
            end
            if (m == 0)
                sp[0] <= 16'h8000;
            @(posedge clk);
            meas_strobe <= 1'b0;
            for (i = 0; i < 3; i = i + 1) begin
                rd_chk(i == 0 ? `CMCR_ADDR_ENC_SPEED : `CMCR_ADDR_CHA_SPEED - 16'h1 + i[15:0],
                    (m[0] == (i != 0)) ? sp[i] : 16'h0000);
                i_cmcr_host.rd_pair(i == 0 ? `CMCR_ADDR_ENC_FREQ :
                    `CMCR_ADDR_CHA_FREQ - 16'h2 + {i[14:0], 1'b0}, v);
                chk_val("freq", (m[0] == (i != 0)) ? fq[i] : 32'h0, v);
            end
        end
        // A new sample between the two halves must not tear the float.
        i_cmcr_host.acc(1'b0, `CMCR_ADDR_CHA_FREQ, 16'h0000, q, rk, re);
        chk_val("freq lo", {16'h0000, fq[1][15:0]}, {16'h0000, q});
        @(posedge clk);
        meas_strobe <= 1'b1;
        fq[1] <= ~fq[1];
        @(posedge clk);
        meas_strobe <= 1'b0;
        rd_chk(`CMCR_ADDR_CHA_FREQ + 16'h0001, ~fq[1][31:16]);
        rd_chk(`CMCR_ADDR_CHA_FREQ + 16'h0001, fq[1][31:16]);
        wrap_up;
    end
endmodule
